// file: verilog/cmul_pkg.sv
/*
 * Shared constants and types for the stream-fed complex multiplier:
 * register offsets, field positions, reset values and pipeline counts.
 * Assumes a 32-bit APB register bus with 8-bit byte addresses.
 */
package cmul_pkg;

    // default operand and sideband widths
    localparam int FIRST_OPERAND_WIDTH_DEF  = 16;
    localparam int SECOND_OPERAND_WIDTH_DEF = 16;
    localparam int USER_W_DEF               = 1;
    localparam int CTRL_DATA_W              = 8;  // control stream byte
    localparam int CTRL_ROUND_BIT           = 0;  // bit that picks rounding

    // pipeline: operand stage, sum stage, output stage
    localparam int NATIVE_LATENCY = 3;

    // APB register map (byte addresses)
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  CFG_OFF    = 8'h00;
    localparam logic [7:0]  STAT_OFF   = 8'h04;
    localparam logic [7:0]  COUNT_OFF  = 8'h08;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam int          CNT_W      = 16;

    // configuration field positions
    localparam int CFG_NONBLK_BIT   = 0;
    localparam int CFG_RANDOM_BIT   = 1;
    localparam int CFG_LASTSEL_LSB  = 2;
    localparam int LASTSEL_W        = 3;

    // output last-marker selection
    typedef enum logic [LASTSEL_W-1:0] {
        LAST_NONE        = 3'h0,
        LAST_FROM_A      = 3'h1,
        LAST_FROM_B      = 3'h2,
        LAST_FROM_CTRL   = 3'h3,
        ANY_INPUT_LAST   = 3'h4,
        EVERY_INPUT_LAST = 3'h5
    } last_sel_e;

    // configuration register layout, lsb first from the bottom
    typedef struct packed {
        last_sel_e lastSel;      // [4:2]
        logic      roundRandom;  // [1]
        logic      nonBlocking;  // [0]
    } cfg_s;

endpackage : cmul_pkg

// file: verilog/complex_multiplier_axis.sv
/*
 * Stream-fed complex multiplier with an APB register port.
 * Assumes all streams and the bus run on core_clk; no clock crossing.
 */
//
// What this block does
// - two operand slaves, control slave, one result master
// - all components are signed two's complement
// - full width is first plus second plus one
// - narrow output keeps top bits, truncates or rounds
// - wide output is sign-extended
// - random mode uses control bit 0 per operation
// - rounding only when low bits are dropped
// - blocking mode waits for every enabled channel
// - non-blocking mode fires on any arriving channel
// - optional last and user per operand channel
// - optional last and user on control channel
// - output last: none, copied, OR or AND
// - clock enable low freezes every register except the registered reset
// - synchronous reset overrides the clock enable
// - one-cycle reset still works, response delayed
// - three multipliers for resources on multiplier slices, four for speed or fabric logic
// - operand valids are independent of each other
// - output valid only with a real product
// - latency automatic or manual minimum, never less
`timescale 1ns/1ps
module complex_multiplier_axis
    import cmul_pkg::*;
#(
    parameter int FIRST_OPERAND_WIDTH  = FIRST_OPERAND_WIDTH_DEF,
    parameter int SECOND_OPERAND_WIDTH = SECOND_OPERAND_WIDTH_DEF,
    parameter int OUT_W       = FIRST_OPERAND_WIDTH + SECOND_OPERAND_WIDTH + 1,
    parameter int A_USER_W    = USER_W_DEF,
    parameter int B_USER_W    = USER_W_DEF,
    parameter int CTRL_USER_W = USER_W_DEF,
    parameter bit HAS_A_LAST  = 1'b1,
    parameter bit HAS_B_LAST  = 1'b1,
    parameter bit HAS_C_LAST  = 1'b1,
    parameter bit HAS_A_USER  = 1'b1,
    parameter bit HAS_B_USER  = 1'b1,
    parameter bit HAS_C_USER  = 1'b1,
    parameter bit FABRIC_LOGIC_BUILD = 1'b0,
    parameter bit OPT_PERFORMANCE    = 1'b0,
    parameter int MIN_LATENCY        = NATIVE_LATENCY
) (
    // clock, clock enable, reset
    input  wire logic                                core_clk,
    input  wire logic                                clkEn,
    input  wire logic                                sys_rst,
    // operand A stream (real low half, imaginary high half)
    input  wire logic                                aValid,
    output logic                                     aReady,
    input  wire logic [2*FIRST_OPERAND_WIDTH-1:0]    aData,
    input  wire logic                                aLast,
    input  wire logic [A_USER_W-1:0]                 aUser,
    // operand B stream
    input  wire logic                                bValid,
    output logic                                     bReady,
    input  wire logic [2*SECOND_OPERAND_WIDTH-1:0]   bData,
    input  wire logic                                bLast,
    input  wire logic [B_USER_W-1:0]                 bUser,
    // rounding control stream
    input  wire logic                                ctrlValid,
    output logic                                     ctrlReady,
    input  wire logic [CTRL_DATA_W-1:0]              ctrlData,
    input  wire logic                                ctrlLast,
    input  wire logic [CTRL_USER_W-1:0]              ctrlUser,
    // product stream
    output logic                                     doutValid,
    input  wire logic                                doutReady,
    output logic [2*OUT_W-1:0]                       doutData,
    output logic                                     doutLast,
    output logic [A_USER_W+B_USER_W+CTRL_USER_W-1:0] doutUser,
    // APB register port
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [ADDR_W-1:0]                   paddr,
    input  wire logic [31:0]                         pwdata,
    output logic [31:0]                              prdata,
    output logic                                     pready,
    output logic                                     pslverr
);

    ////////////////////////////////////////////////////////////////////////
    // derived sizes
    localparam int FW     = FIRST_OPERAND_WIDTH;
    localparam int SW     = SECOND_OPERAND_WIDTH;
    localparam int FULL_W = FW + SW + 1;
    localparam int MW     = FW + SW + 2;                       // product room
    localparam int UO_W   = A_USER_W + B_USER_W + CTRL_USER_W;
    localparam int TAG_W  = 2 + UO_W;                          // rb, last, user
    localparam int PW     = 1 + TAG_W + 2 * FULL_W;            // stage word
    localparam int DROP_W = (OUT_W < FULL_W) ? FULL_W - OUT_W : 0;
    localparam int EXTRA  = (MIN_LATENCY > NATIVE_LATENCY) ?
                            MIN_LATENCY - NATIVE_LATENCY : 0;
    // three-multiplier form only when building from multiplier slices
    // for resources; performance always takes four
    localparam bit THREE  = !FABRIC_LOGIC_BUILD && !OPT_PERFORMANCE;

    ////////////////////////////////////////////////////////////////////////
    // reset is registered once, so a pulse acts one edge late
    logic rstQ_ff;                                // registered reset
    always_ff @(posedge core_clk) begin
        rstQ_ff <= sys_rst;
    end

    ////////////////////////////////////////////////////////////////////////
    // declarations
    cfg_s                      cfg_ff;            // software configuration
    logic                      doutValid_ff;      // output holds product
    logic [2*OUT_W-1:0]        doutData_ff;       // output product
    logic                      doutLast_ff;       // output marker
    logic [UO_W-1:0]           doutUser_ff;       // output sideband
    logic                      s1Valid_ff;        // products stage valid
    logic [TAG_W-1:0]          s1Tag_ff;          // products stage tag
    logic signed [MW-1:0]      m0_ff, m1_ff;      // ar*br, ai*bi
    logic signed [MW-1:0]      m2_ff, m3_ff;      // cross products; shared product and zero when THREE
    logic [PW-1:0]             pipe_ff [0:EXTRA]; // sum stage and delays
    logic [2*FW-1:0]           aHold_ff;          // last A taken
    logic [2*SW-1:0]           bHold_ff;          // last B taken
    logic                      rbHold_ff;         // last round bit taken
    logic [CNT_W-1:0]          count_ff;          // products delivered
    logic [31:0]               prdata_ff;         // read data
    logic                      rdFresh_ff;        // read data loaded

    ////////////////////////////////////////////////////////////////////////
    // flow control
    wire advance   = clkEn && !rstQ_ff && (!doutValid_ff || doutReady);
    wire randomOn  = cfg_ff.roundRandom && (DROP_W > 0);
    wire allValid  = aValid && bValid && (!randomOn || ctrlValid);
    wire anyValid  = aValid || bValid || (randomOn && ctrlValid);
    wire opFire    = advance && (cfg_ff.nonBlocking ? anyValid : allValid);
    wire chanReady = advance && (cfg_ff.nonBlocking || allValid);
    // each operand channel is taken on its own valid and ready
    assign aReady    = chanReady;
    assign bReady    = chanReady;
    assign ctrlReady = chanReady && randomOn;
    wire aTake = aValid && aReady;
    wire bTake = bValid && bReady;
    wire cTake = ctrlValid && ctrlReady;

    // absent channels reuse the last value taken (non-blocking only)
    wire [2*FW-1:0] aUse  = aTake ? aData : aHold_ff;
    wire [2*SW-1:0] bUse  = bTake ? bData : bHold_ff;
    wire            rbUse = cTake ? ctrlData[CTRL_ROUND_BIT]
                                  : rbHold_ff;
    wire signed [FW-1:0] ar = aUse[FW-1:0];
    wire signed [FW-1:0] ai = aUse[2*FW-1:FW];
    wire signed [SW-1:0] br = bUse[SW-1:0];
    wire signed [SW-1:0] bi = bUse[2*SW-1:SW];

    ////////////////////////////////////////////////////////////////////////
    // markers and sideband of the operation being started
    wire aLastIn = HAS_A_LAST && aTake && aLast;
    wire bLastIn = HAS_B_LAST && bTake && bLast;
    wire cOn     = HAS_C_LAST && randomOn;
    wire cLastIn = cOn && cTake && ctrlLast;
    wire anyLast = aLastIn || bLastIn || cLastIn;
    // missing markers do not veto the AND; no marker at all gives zero
    wire somePresent = HAS_A_LAST || HAS_B_LAST || cOn;
    wire everyLast   = somePresent
                     && (aLastIn || !HAS_A_LAST)
                     && (bLastIn || !HAS_B_LAST)
                     && (cLastIn || !cOn);
    wire lastSelNow =
        (cfg_ff.lastSel == LAST_FROM_A)      ? aLastIn   :
        (cfg_ff.lastSel == LAST_FROM_B)      ? bLastIn   :
        (cfg_ff.lastSel == LAST_FROM_CTRL)   ? cLastIn   :
        (cfg_ff.lastSel == ANY_INPUT_LAST)   ? anyLast   :
        (cfg_ff.lastSel == EVERY_INPUT_LAST) ? everyLast :
                                               1'b0;
    wire [A_USER_W-1:0]    aUserIn = (HAS_A_USER && aTake) ? aUser : '0;
    wire [B_USER_W-1:0]    bUserIn = (HAS_B_USER && bTake) ? bUser : '0;
    wire [CTRL_USER_W-1:0] cUserIn = (HAS_C_USER && cTake) ? ctrlUser
                                                           : '0;
    wire [TAG_W-1:0] tagNow = {rbUse, lastSelNow, cUserIn, bUserIn,
                               aUserIn};

    ////////////////////////////////////////////////////////////////////////
    // multiplier structure
    wire signed [MW-1:0] nxt_m0 = MW'(ar) * MW'(br);
    wire signed [MW-1:0] nxt_m1 = MW'(ai) * MW'(bi);
    logic signed [MW-1:0] nxt_m2, nxt_m3;
    generate
        if (THREE) begin : g_three
            // one shared product replaces the two cross terms
            wire signed [FW:0] aSum = (FW+1)'(ar) + (FW+1)'(ai);
            wire signed [SW:0] bSum = (SW+1)'(br) + (SW+1)'(bi);
            assign nxt_m2 = MW'(aSum) * MW'(bSum);
            assign nxt_m3 = '0;
        end else begin : g_four
            assign nxt_m2 = MW'(ar) * MW'(bi);
            assign nxt_m3 = MW'(ai) * MW'(br);
        end
    endgenerate
    wire signed [MW-1:0] sumRe = m0_ff - m1_ff;
    wire signed [MW-1:0] sumIm = THREE ? m2_ff - m0_ff - m1_ff
                                       : m2_ff + m3_ff;

    // operand and products stage
    always_ff @(posedge core_clk) begin
        if (rstQ_ff) begin
            s1Valid_ff <= 1'b0;
            s1Tag_ff   <= '0;
            m0_ff      <= '0;
            m1_ff      <= '0;
            m2_ff      <= '0;
            m3_ff      <= '0;
        end else if (advance) begin
            s1Valid_ff <= opFire;
            s1Tag_ff   <= tagNow;
            m0_ff      <= nxt_m0;
            m1_ff      <= nxt_m1;
            m2_ff      <= nxt_m2;
            m3_ff      <= nxt_m3;
        end
    end

    // held operands for non-blocking reuse
    always_ff @(posedge core_clk) begin
        if (rstQ_ff) begin
            aHold_ff  <= '0;
            bHold_ff  <= '0;
            rbHold_ff <= 1'b0;
        end else if (clkEn) begin
            if (aTake) aHold_ff <= aData;
            if (bTake) bHold_ff <= bData;
            if (cTake) rbHold_ff <= ctrlData[CTRL_ROUND_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sum stage and manual latency padding; the whole pipe stalls
    // together, which keeps bubbles but needs no per-stage ready
    always_ff @(posedge core_clk) begin
        if (rstQ_ff) begin
            pipe_ff[0] <= '0;
        end else if (advance) begin
            pipe_ff[0] <= {s1Valid_ff, s1Tag_ff, FULL_W'(sumIm),
                           FULL_W'(sumRe)};
        end
    end
    generate
        for (genvar i = 1; i <= EXTRA; i++) begin : g_pad
            always_ff @(posedge core_clk) begin
                if (rstQ_ff) begin
                    pipe_ff[i] <= '0;
                end else if (advance) begin
                    pipe_ff[i] <= pipe_ff[i-1];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // scaling of each component into the output width
    wire [PW-1:0]  last_w  = pipe_ff[EXTRA];
    wire           tailV   = last_w[PW-1];
    wire           tailRb  = last_w[PW-2];
    wire           tailLst = last_w[PW-3];
    wire [UO_W-1:0] tailUsr = last_w[PW-4 -: UO_W];
    logic [OUT_W-1:0] scaled [0:1];
    generate
        for (genvar k = 0; k < 2; k++) begin : g_comp
            wire signed [FULL_W-1:0] full = last_w[k*FULL_W +: FULL_W];
            if (DROP_W > 0) begin : g_drop
                // half minus one plus the random bit rounds either way
                localparam logic [FULL_W:0] HALF_M1 =
                    (FULL_W+1)'((1 << (DROP_W - 1)) - 1);
                wire [FULL_W:0] addend = randomOn ?
                    HALF_M1 + (FULL_W+1)'(tailRb) : '0;
                wire [FULL_W:0] wide = {full[FULL_W-1], full} + addend;
                assign scaled[k] = wide[FULL_W-1 -: OUT_W];
            end else begin : g_ext
                assign scaled[k] = OUT_W'(full);
            end
        end
    endgenerate

    // output register, loaded only when the master side can move
    always_ff @(posedge core_clk) begin
        if (rstQ_ff) begin
            doutValid_ff <= 1'b0;
            doutData_ff  <= '0;
            doutLast_ff  <= 1'b0;
            doutUser_ff  <= '0;
        end else if (advance) begin
            doutValid_ff <= tailV;
            doutData_ff  <= {scaled[1], scaled[0]};
            doutLast_ff  <= tailV && tailLst;
            doutUser_ff  <= tailUsr;
        end
    end
    assign doutValid = doutValid_ff;
    assign doutData  = doutData_ff;
    assign doutLast  = doutLast_ff;
    assign doutUser  = doutUser_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states unless the clock enable is low
    wire hitCfg   = (paddr == CFG_OFF);
    wire hitStat  = (paddr == STAT_OFF);
    wire hitCount = (paddr == COUNT_OFF);
    wire hitAny   = hitCfg || hitStat || hitCount;
    wire access   = psel && penable && pready;
    wire wrCfg    = access && pwrite && hitCfg;
    wire wrCount  = access && pwrite && hitCount;
    wire delivered = clkEn && doutValid_ff && doutReady;
    wire [31:0] statWord = {28'h0, randomOn, doutValid_ff, s1Valid_ff,
                            tailV};
    wire [31:0] readMux  = hitCfg   ? {27'h0, cfg_ff}           :
                           hitStat  ? statWord                   :
                           hitCount ? {{(32-CNT_W){1'b0}}, count_ff} :
                                      32'h0;
    assign pready  = clkEn && rdFresh_ff;
    assign pslverr = psel && penable && !hitAny;
    assign prdata  = prdata_ff;

    // configuration and read data capture; read data is loaded at the
    // first enabled edge of a transfer, so a gated setup edge cannot
    // hand back stale data, it only costs one wait state
    always_ff @(posedge core_clk) begin
        if (rstQ_ff) begin
            cfg_ff     <= cfg_s'(CFG_RESET[4:0]);
            prdata_ff  <= 32'h0;
            rdFresh_ff <= 1'b0;
        end else if (clkEn) begin
            if (wrCfg) cfg_ff <= cfg_s'(pwdata[4:0]);
            if (psel && !rdFresh_ff) prdata_ff <= readMux;
            rdFresh_ff <= psel && !access;
        end
    end

    // delivered-product counter; a write clears, a same-cycle delivery
    // still counts so no product is lost
    always_ff @(posedge core_clk) begin
        if (rstQ_ff) begin
            count_ff <= '0;
        end else if (clkEn) begin
            count_ff <= (wrCount ? '0 : count_ff) + CNT_W'(delivered);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rstQ_ff);

    sequence s_stall;
        doutValid && !doutReady;
    endsequence
    property p_outHold;
        s_stall |=> doutValid && $stable(doutData) && $stable(doutLast);
    endproperty
    a_outHold: assert property (p_outHold)
        else $error("output changed while stalled");

    property p_blockWait;
        opFire && !cfg_ff.nonBlocking |-> aValid && bValid;
    endproperty
    a_blockWait: assert property (p_blockWait)
        else $error("blocking mode fired without all operands");

    property p_nonBlockGo;
        advance && cfg_ff.nonBlocking && (aValid || bValid) |-> opFire;
    endproperty
    a_nonBlockGo: assert property (p_nonBlockGo)
        else $error("non-blocking mode failed to start");

    property p_freeze;
        !clkEn |=> $stable(doutValid) && $stable(count_ff)
                   && $stable(s1Valid_ff);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    property p_resetLate;
        disable iff (1'b0) sys_rst |-> ##2 !doutValid && !s1Valid_ff;
    endproperty
    a_resetLate: assert property (p_resetLate)
        else $error("reset did not clear the pipeline");

    property p_lastNone;
        doutValid && $past(cfg_ff.lastSel) == LAST_NONE
            && $stable(cfg_ff) |-> !doutLast;
    endproperty
    a_lastNone: assert property (p_lastNone)
        else $error("last marker raised with selection none");

    property p_ctrlIdle;
        !randomOn |-> !ctrlReady;
    endproperty
    a_ctrlIdle: assert property (p_ctrlIdle)
        else $error("control stream taken outside random mode");

    property p_validCause;
        $rose(doutValid) |-> $past(tailV);
    endproperty
    a_validCause: assert property (p_validCause)
        else $error("output valid without a product behind it");

endmodule : complex_multiplier_axis

// file: bench/stream_sink_model.sv
/*
 * downstream sink model for the product stream: drives the ready.
 * assumes the bench clock and reset; slow mode stalls about half the time.
 */
`timescale 1ns/1ps
module stream_sink_model (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // stall control
    input  wire logic slowMode,
    // result stream ready
    output logic      doutReady
);
    logic [15:0] pat_ff;  // stall pattern shift register

    ////////////////////////////////////////////////////////////////////////
    // ready may drop at any edge; the sender must hold until taken
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pat_ff    <= 16'hACE1;
            doutReady <= 1'b0;
        end else begin
            pat_ff    <= {pat_ff[14:0], pat_ff[15] ^ pat_ff[13] ^ pat_ff[12]};
            doutReady <= !slowMode | pat_ff[0];  // slow mode: random stalls
        end
    end
endmodule : stream_sink_model

// file: bench/tb_complex_multiplier_axis.sv
/*
 * bench for the complex multiplier: random operands, every marker mode,
 * blocking and non-blocking flow, register reads over the bus.
 * assumes default widths (16, 16, 33) and the sink model on the result.
 */
`timescale 1ns/1ps
module tb_complex_multiplier_axis;
    import cmul_pkg::*;
    logic        core_clk, sys_rst, slowMode, gateOn;
    logic        clkEn = 1'b1;                 // driven by the gap process
    logic [31:0] gateSeed = 32'h938EF82F;      // gap pattern state
    logic        aValid, aReady, aLast, aUser;
    logic        bValid, bReady, bLast, bUser;
    logic        ctrlReady, doutValid, doutReady, doutLast;
    logic [31:0] aData, bData, pwdata, prdata, seed, rd, holdA, holdB;
    logic [65:0] doutData;
    logic [2:0]  doutUser;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [68:0] expQ[$];  // {last, b user, a user, product}
    int          err_count, checks_done;

    complex_multiplier_axis dut (
        .core_clk(core_clk), .clkEn(clkEn), .sys_rst(sys_rst),
        .aValid(aValid), .aReady(aReady), .aData(aData),
        .aLast(aLast), .aUser(aUser),
        .bValid(bValid), .bReady(bReady), .bData(bData),
        .bLast(bLast), .bUser(bUser),
        .ctrlValid(1'b0), .ctrlReady(ctrlReady), .ctrlData(8'h00),
        .ctrlLast(1'b0), .ctrlUser(1'b0),
        .doutValid(doutValid), .doutReady(doutReady),
        .doutData(doutData), .doutLast(doutLast), .doutUser(doutUser),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    stream_sink_model sink (.core_clk(core_clk), .sys_rst(sys_rst),
        .slowMode(slowMode), .doutReady(doutReady));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // full-precision product, imaginary half on top
    function automatic logic [65:0] cprod(input logic [31:0] a, b);
        logic signed [32:0] re, im;
        re = $signed(a[15:0]) * $signed(b[15:0])
           - $signed(a[31:16]) * $signed(b[31:16]);
        im = $signed(a[15:0]) * $signed(b[31:16])
           + $signed(a[31:16]) * $signed(b[15:0]);
        return {im, re};
    endfunction : cprod
    // marker expected for a selection; absent ones read 0
    function automatic logic lastOf(input int sel, input logic la, lb);
        case (sel)
            1: return la;
            2: return lb;
            4: return la | lb;
            5: return la & lb;
            default: return 1'b0;  // none, or control marker not present
        endcase
    endfunction : lastOf
    task automatic chk(input string what, input logic [68:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    // one bus transfer: setup, then access until the slave answers
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd, output logic err);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one operation; each valid is raised on its own
    task automatic op(input logic va, vb, input int sel);
        logic [31:0] da, db;
        logic        la, lb, ua, ub;
        da = seed;
        seed = lfsr(seed);
        db = seed;
        seed = lfsr(seed);
        {la, lb, ua, ub} = seed[3:0];
        seed = lfsr(seed);
        aValid <= va;
        aData  <= da;
        aLast  <= la;
        aUser  <= ua;
        bValid <= vb;
        bData  <= db;
        bLast  <= lb;
        bUser  <= ub;
        do @(posedge core_clk); while ((va ? aReady : bReady) !== 1'b1);
        if (va) holdA = da;
        if (vb) holdB = db;
        expQ.push_back({lastOf(sel, la & va, lb & vb), ub & vb, ua & va,
                        cprod(holdA, holdB)});
    endtask : op

    ////////////////////////////////////////////////////////////////////////
    // result monitor: every beat taken must match the oldest expectation
    always @(posedge core_clk) begin
        // a beat only leaves on an enabled edge
        if (!sys_rst && clkEn === 1'b1 && doutValid === 1'b1
            && doutReady === 1'b1) begin
            if (expQ.size() == 0) chk("spurious beat", 0, 1);
            else chk("product", expQ.pop_front(),
                     {doutLast, doutUser[1:0], doutData});
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // clock-enable gaps, about one edge in four once switched on
    always @(posedge core_clk) begin
        gateSeed <= lfsr(gateSeed);
        clkEn    <= !gateOn || gateSeed[1:0] != 2'b00;
    end
    initial begin
        #300000;
        err_count++;
        end_sim();
    end
    initial begin
        logic       e;
        logic [1:0] v;
        {sys_rst, slowMode, psel, penable, pwrite, gateOn} = 6'b100000;
        {aValid, aLast, aUser, bValid, bLast, bUser} = 6'b0;
        {aData, bData, pwdata, paddr, holdA, holdB} = '0;
        seed = 32'h938EF82F;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        // blocking mode, every marker selection, fast and slow sink
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, CFG_OFF, 32'(s) << CFG_LASTSEL_LSB, e);
            apb(1'b0, CFG_OFF, 32'h0, e);
            chk("cfg readback", 32'(s) << CFG_LASTSEL_LSB, rd);
            slowMode <= s[0];
            aValid   <= 1'b1;
            repeat (4) @(posedge core_clk);
            chk("lone A refused", 0, aReady);
            repeat (8) op(1'b1, 1'b1, s);
            aValid <= 1'b0;
            bValid <= 1'b0;
        end
        // non-blocking mode: either channel alone starts an operation;
        // from here on the clock enable drops at random
        gateOn <= 1'b1;
        apb(1'b1, CFG_OFF, 32'h11, e);
        repeat (12) begin
            v = seed[1:0] == 2'b00 ? 2'b11 : seed[1:0];
            op(v[0], v[1], 4);
        end
        aValid <= 1'b0;
        bValid <= 1'b0;
        repeat (60) @(posedge core_clk);
        chk("all delivered", 0, expQ.size());
        apb(1'b0, COUNT_OFF, 32'h0, e);
        chk("count", 60, rd);
        apb(1'b0, 8'h0C, 32'h0, e);
        chk("unmapped error", 1, e);
        // a one-cycle reset pulse must still clear the block
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        apb(1'b0, COUNT_OFF, 32'h0, e);
        chk("count after pulse", 0, rd);
        end_sim();
    end
endmodule : tb_complex_multiplier_axis
